// ==== verilog/epi_pkg.sv ====
// package for the external pin interrupt unit: register map, field layout, sense codes
// assumes a 32-bit apb slave with word-aligned registers
`default_nettype none
package epi_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GMASK = 8'h04;
  localparam logic [7:0] ADDR_PCMASK = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IMASK = 8'h10;
  localparam logic [7:0] ADDR_GIE = 8'h14;
  localparam logic [7:0] ADDR_PINS = 8'h18;
  localparam int BIT_EXT_EN = 6;
  localparam int BIT_PC_EN = 5;
  localparam int NUM_PC = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] GMASK_WMASK = 8'h60;
  localparam int ST_EXT = 0;
  localparam int ST_PC = 1;
  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_ANY = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } epi_sense_e;
endpackage : epi_pkg
`default_nettype wire

// ==== verilog/epi_top.sv ====
// external pin interrupt unit: one sensed pin, six maskable pin-change inputs, apb registers
// assumes pins are asynchronous to clock; request paths sample pins through three flip-flops, the wake flop takes them directly
`timescale 1ns/100ps
`default_nettype none
module epi_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extIrqPin,
  input wire logic [5:0] pinChangeInputs,
  input wire logic sleepClamp,
  input wire logic extAck,
  input wire logic pcAck,
  output logic extIrqReq,
  output logic pcIrqReq,
  output logic extClampBypass,
  output logic asyncWake,
  output logic irq
);
  logic [7:0] mcuControl_q;
  logic [7:0] genMask_q;
  logic [5:0] pinChangeMask_q;
  logic [1:0] status_q;
  logic [1:0] irqMask_q;
  logic globalEn_q;
  logic [2:0] extSync_q;
  logic [5:0] pcSync0_q;
  logic [5:0] pcSync1_q;
  logic [5:0] pcSync2_q;
  logic extLevel_q;
  logic [5:0] pcLevel_q;
  logic extPend_q;
  logic pcPend_q;
  logic extIrqReq_d;
  logic extEdge;
  logic [5:0] pcToggle;
  logic [31:0] rdata_d;
  logic wrEn;
  logic rdEn;
  logic addrOk;

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[7:0] == epi_pkg::ADDR_CTRL) || (a[7:0] == epi_pkg::ADDR_GMASK) ||
             (a[7:0] == epi_pkg::ADDR_PCMASK) || (a[7:0] == epi_pkg::ADDR_STATUS) ||
             (a[7:0] == epi_pkg::ADDR_IMASK) || (a[7:0] == epi_pkg::ADDR_GIE) ||
             (a[7:0] == epi_pkg::ADDR_PINS);
  endfunction : mapped

  // one register hit, used by every write and by the read-clear
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[7:0] == off);
  endfunction : hit

  assign addrOk = mapped(paddr) && (paddr[31:8] == 24'h000000);
  assign wrEn = psel && penable && pwrite && pready && addrOk;
  assign rdEn = psel && penable && !pwrite && pready && addrOk;

  // three-stage sampling of the dedicated pin, driven or not
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      extSync_q <= 3'h7;
    else
      extSync_q <= {extSync_q[1:0], extIrqPin};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      extLevel_q <= 1'b1;
    else if (extSync_q[1] == extSync_q[2])
      extLevel_q <= extSync_q[2];
  end

  // pin-change inputs sampled per bit
  genvar gi;
  generate
    for (gi = 0; gi < epi_pkg::NUM_PC; gi++)
    begin : g_pc
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pcSync0_q[gi] <= 1'b0;
          pcSync1_q[gi] <= 1'b0;
          pcSync2_q[gi] <= 1'b0;
          pcLevel_q[gi] <= 1'b0;
        end
        else
        begin
          pcSync0_q[gi] <= pinChangeInputs[gi];
          pcSync1_q[gi] <= pcSync0_q[gi];
          pcSync2_q[gi] <= pcSync1_q[gi];
          if (pcSync1_q[gi] == pcSync2_q[gi])
            pcLevel_q[gi] <= pcSync2_q[gi];
        end
      end
      assign pcToggle[gi] = (pcSync1_q[gi] == pcSync2_q[gi]) && (pcSync2_q[gi] != pcLevel_q[gi]) &&
                            pinChangeMask_q[gi];
    end
  endgenerate

  // edge decode on the clocked path only
  always_comb
  begin
    extEdge = 1'b0;
    if (extSync_q[1] == extSync_q[2] && extSync_q[2] != extLevel_q)
    begin
      case (epi_pkg::epi_sense_e'(mcuControl_q[1:0]))
        epi_pkg::SENSE_LOW: extEdge = 1'b0;
        epi_pkg::SENSE_ANY: extEdge = 1'b1;
        epi_pkg::SENSE_FALL: extEdge = !extSync_q[2];
        epi_pkg::SENSE_RISE: extEdge = extSync_q[2];
        default: extEdge = 1'b0;
      endcase
    end
  end

  // dedicated pin pending, a new event wins over service
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      extPend_q <= 1'b0;
    else
      extPend_q <= extEdge || (extPend_q && !extAck);
  end

  // pin-change pending, a new toggle wins over service
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pcPend_q <= 1'b0;
    else
      pcPend_q <= (|pcToggle) || (pcPend_q && !pcAck);
  end

  // low level asserts while held; enables gate both
  always_comb
  begin
    if (mcuControl_q[1:0] == epi_pkg::SENSE_LOW)
      extIrqReq_d = !extLevel_q;
    else
      extIrqReq_d = extPend_q;
    extIrqReq_d = extIrqReq_d && globalEn_q && genMask_q[epi_pkg::BIT_EXT_EN];
  end

  // dedicated pin request output
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      extIrqReq <= 1'b0;
    else
      extIrqReq <= extIrqReq_d;
  end

  // pin-change request output
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pcIrqReq <= 1'b0;
    else
      pcIrqReq <= pcPend_q && globalEn_q && genMask_q[epi_pkg::BIT_PC_EN];
  end

  // input clamp released for an enabled pin
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      extClampBypass <= 1'b0;
    else
      extClampBypass <= genMask_q[epi_pkg::BIT_EXT_EN] || !sleepClamp;
  end

  // wake request held in a flop for the sleep controller
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      asyncWake <= 1'b0;
    else
      asyncWake <= (genMask_q[epi_pkg::BIT_EXT_EN] && (mcuControl_q[1:0] == epi_pkg::SENSE_LOW) && !extIrqPin) ||
                   (genMask_q[epi_pkg::BIT_PC_EN] && (|(pinChangeMask_q & (pinChangeInputs ^ pcLevel_q))));
  end

  // sense field and storage bits
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mcuControl_q <= epi_pkg::CTRL_RESET;
    else if (wrEn && hit(paddr, epi_pkg::ADDR_CTRL))
      mcuControl_q <= pwdata[7:0];
  end

  // enable bits 6 and 5 only
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      genMask_q <= epi_pkg::CTRL_RESET;
    else if (wrEn && hit(paddr, epi_pkg::ADDR_GMASK))
      genMask_q <= pwdata[7:0] & epi_pkg::GMASK_WMASK;
  end

  // per-pin change mask
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pinChangeMask_q <= 6'h00;
    else if (wrEn && hit(paddr, epi_pkg::ADDR_PCMASK))
      pinChangeMask_q <= pwdata[5:0];
  end

  // status to irq mask
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irqMask_q <= 2'h0;
    else if (wrEn && hit(paddr, epi_pkg::ADDR_IMASK))
      irqMask_q <= pwdata[1:0];
  end

  // global enable
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      globalEn_q <= 1'b0;
    else if (wrEn && hit(paddr, epi_pkg::ADDR_GIE))
      globalEn_q <= pwdata[0];
  end

  // sticky dedicated pin status, cleared by read, set wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      status_q[epi_pkg::ST_EXT] <= 1'b0;
    else if (extIrqReq_d)
      status_q[epi_pkg::ST_EXT] <= 1'b1;
    else if (rdEn && hit(paddr, epi_pkg::ADDR_STATUS))
      status_q[epi_pkg::ST_EXT] <= 1'b0;
  end

  // sticky pin-change status, cleared by read, set wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      status_q[epi_pkg::ST_PC] <= 1'b0;
    else if (pcPend_q && genMask_q[epi_pkg::BIT_PC_EN])
      status_q[epi_pkg::ST_PC] <= 1'b1;
    else if (rdEn && hit(paddr, epi_pkg::ADDR_STATUS))
      status_q[epi_pkg::ST_PC] <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(status_q & irqMask_q);
  end

  always_comb
  begin
    rdata_d = 32'h00000000;
    case (paddr[7:0])
      epi_pkg::ADDR_CTRL: rdata_d[7:0] = mcuControl_q;
      epi_pkg::ADDR_GMASK: rdata_d[7:0] = genMask_q;
      epi_pkg::ADDR_PCMASK: rdata_d[5:0] = pinChangeMask_q;
      epi_pkg::ADDR_STATUS: rdata_d[1:0] = status_q;
      epi_pkg::ADDR_IMASK: rdata_d[1:0] = irqMask_q;
      epi_pkg::ADDR_GIE: rdata_d[0] = globalEn_q;
      epi_pkg::ADDR_PINS: rdata_d[6:0] = {extLevel_q, pcLevel_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // one wait state: ready in the second access cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  // read data stands with ready
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else
      prdata <= rdata_d;
  end

  // error for any unmapped address
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pslverr <= 1'b0;
    else
      pslverr <= psel && penable && !pready && !addrOk;
  end
endmodule : epi_top
`default_nettype wire

// ==== tb/epi_checker.sv ====
// checker for the pin interrupt unit: apb timing, clamp release, acknowledge, reset
// assumes bound to epi_top, seeing only its ports
`timescale 1ns/100ps
`default_nettype none
module epi_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic extIrqPin,
  input wire logic [5:0] pinChangeInputs,
  input wire logic sleepClamp,
  input wire logic extAck,
  input wire logic pcAck,
  input wire logic extIrqReq,
  input wire logic pcIrqReq,
  input wire logic extClampBypass,
  input wire logic asyncWake,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  AST_READY_ONE: assert property (s_wait |=> pready) else $error("no answer after one wait");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR_UNMAPPED: assert property (pready && (paddr > 32'h18 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped without error");
  AST_ERR_MAPPED: assert property (pready && paddr <= 32'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped with error");
  AST_ERR_RDATA: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("error read data");
  AST_CLAMP: assert property (!sleepClamp |=> extClampBypass) else $error("clamp kept");
  AST_PC_ACK: assert property (pcAck && pinChangeInputs == $past(pinChangeInputs, 6) |-> ##2 !pcIrqReq)
    else $error("pin change pending kept");
  AST_RESET_QUIET: assert property ($rose(rst_n) |-> !irq && !pready && !extIrqReq && !pcIrqReq)
    else $error("output active after reset");
endmodule : epi_checker
`default_nettype wire

// ==== tb/epi_pin_drv.sv ====
// far-side model: external circuitry driving the dedicated pin and pin-change inputs
// assumes the bench calls drive; levels change just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module epi_pin_drv (
  input wire logic clock,
  output logic extIrqPin,
  output logic [5:0] pinChangeInputs
);
  initial
  begin
    extIrqPin = 1'b1;
    pinChangeInputs = 6'h00;
  end
  // each level is held ten clocks, well past one clock period
  task automatic drive(input logic e, input logic [5:0] p);
    @(posedge clock);
    extIrqPin <= e;
    pinChangeInputs <= p;
    repeat (10) @(posedge clock);
  endtask : drive
endmodule : epi_pin_drv
`default_nettype wire

// ==== tb/external_pin_interrupt_unit_tb_top.sv ====
// bench: register table, sense modes, pin-change mask, gating, clamp
// assumes epi_top, epi_pin_drv and epi_checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupt_unit_tb_top;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleepClamp = 1'b0, extAck = 1'b0, pcAck = 1'b0, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, extIrqPin, extIrqReq, pcIrqReq, extClampBypass, asyncWake, irq;
  logic [5:0] pinChangeInputs;
  int bad_count = 0, compares = 0;
  logic [31:0] tbl [4][4] = '{'{32'h00, 32'hFF, 32'hFF, 32'h0}, '{32'h04, 32'hFF, 32'h60, 32'h0},
    '{32'h08, 32'hFF, 32'h3F, 32'h0}, '{32'h1C, 32'hFF, 32'h00, 32'h1}};
  always #4 clock = ~clock;
  epi_top uut (.*);
  epi_pin_drv drv (.*);
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        bad_count++;
        tally_and_finish();
      end
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic ack();
    extAck <= 1'b1;
    pcAck <= 1'b1;
    @(posedge clock);
    extAck <= 1'b0;
    pcAck <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : ack
  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, epi_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, epi_pkg::ADDR_GMASK, 32'h0);
    chk(rd, 32'h0);
    foreach (tbl[i])
    begin
      bus(1'b1, tbl[i][0][7:0], tbl[i][1]);
      bus(1'b0, tbl[i][0][7:0], 32'h0);
      chk(rd, tbl[i][2]);
      chk(er, tbl[i][3]);
    end
    $display("register test done");
    bus(1'b1, epi_pkg::ADDR_GIE, 32'h1);
    bus(1'b1, epi_pkg::ADDR_IMASK, 32'h3);
    bus(1'b1, epi_pkg::ADDR_PCMASK, 32'h1);
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, epi_pkg::ADDR_CTRL, m);
      ack();
      drv.drive(1'b0, 6'h00);
      chk(extIrqReq, m != 3);
      ack();
      drv.drive(1'b1, 6'h00);
      chk(extIrqReq, m[0]);
    end
    chk(irq, 1'b1);
    ack();
    bus(1'b0, epi_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h1);
    bus(1'b0, epi_pkg::ADDR_STATUS, 32'h0);
    repeat (2) @(posedge clock);
    chk({rd[30:0], irq}, 32'h0);
    $display("sense test done");
    drv.drive(1'b1, 6'h02);
    chk(pcIrqReq, 1'b0);
    drv.drive(1'b1, 6'h03);
    chk(pcIrqReq, 1'b1);
    ack();
    chk(pcIrqReq, 1'b0);
    bus(1'b1, epi_pkg::ADDR_IMASK, 32'h0);
    drv.drive(1'b1, 6'h00);
    chk(irq, 1'b0);
    $display("pin change test done");
    bus(1'b1, epi_pkg::ADDR_CTRL, 32'h0);
    bus(1'b1, epi_pkg::ADDR_GIE, 32'h0);
    drv.drive(1'b0, 6'h00);
    chk(extIrqReq, 1'b0);
    bus(1'b1, epi_pkg::ADDR_GIE, 32'h1);
    repeat (3) @(posedge clock);
    chk(extIrqReq, 1'b1);
    sleepClamp <= 1'b1;
    bus(1'b1, epi_pkg::ADDR_GMASK, 32'h0);
    repeat (3) @(posedge clock);
    chk({extIrqReq, extClampBypass, asyncWake}, 32'h0);
    bus(1'b1, epi_pkg::ADDR_GMASK, 32'h60);
    repeat (3) @(posedge clock);
    chk(extClampBypass, 1'b1);
    chk(asyncWake, 1'b1);
    $display("gating test done");
    tally_and_finish();
  end
endmodule : external_pin_interrupt_unit_tb_top
bind epi_top epi_checker chk_i (.*);
`default_nettype wire
